// *** logic/ccdiv_pkg.sv ***
// Package for the channel clock divider: register map, fields, resets, types
package ccdiv_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [8:0] DIV0_COUNTS_IDX = 9'h190;
  localparam logic [8:0] DIV0_CTRL_IDX   = 9'h191;
  localparam logic [8:0] DIV0_ROUTE_IDX  = 9'h192;
  localparam logic [8:0] DIV1_COUNTS_IDX = 9'h193;
  localparam logic [8:0] DIV1_CTRL_IDX   = 9'h194;
  localparam logic [8:0] STATUS_IDX      = 9'h19F;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LOW_MSB    = 7;
  localparam int LOW_LSB    = 4;
  localparam int HIGH_MSB   = 3;
  localparam int HIGH_LSB   = 0;
  localparam int BYPASS_BIT = 7;
  localparam int NOSYNC_BIT = 6;
  localparam int FORCE_BIT  = 5;
  localparam int START_BIT  = 4;
  localparam int PHASE_MSB  = 3;
  localparam int PHASE_LSB  = 0;
  localparam int DIRECT_BIT = 1;
  localparam int DUTY_CORRECTION_DISABLE_BIT = 0;

  // ************************************************************
  // Reset values and codes
  // ************************************************************
  localparam logic [7:0] COUNTS_RST    = 8'h00;
  localparam logic [7:0] DIV0_CTRL_RST = 8'h80;
  localparam logic [7:0] DIV1_CTRL_RST = 8'h00;
  localparam logic [7:0] ROUTE_RST     = 8'h00;
  localparam logic [1:0] SRC_OSC       = 2'h2;
  localparam logic [1:0] SRC_EXT       = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [4:0] CNT_ZERO      = 5'h00;
  localparam logic [5:0] RATIO_BIAS    = 6'h02;

  // One divider's running state
  typedef struct packed {
    logic [4:0] cnt;
    logic [3:0] ph;
    logic       lvl;
  } ccdiv_div_t;

  // One divider's settings, taken from its registers
  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
    logic       bypass;
    logic       nosync;
    logic       force_hi;
    logic       start_hi;
    logic [3:0] phase;
  } ccdiv_cfg_t;

endpackage : ccdiv_pkg

// *** logic/ccdiv_top.sv ***
// Channel clock divider pair with AHB-Lite register slave
`timescale 1ns/1ns

module ccdiv_top
  import ccdiv_pkg::*;
(
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic [31:0] hrdata,
  output var   logic        hreadyout,
  output var   logic        hresp,
  input  wire  logic        chip_sync_n,
  input  wire  logic [1:0]  src_select,
  input  wire  logic        internal_oscillator,
  input  wire  logic        ext_clock_level,
  output var   logic        first_pair_output_a,
  output var   logic        first_pair_output_b,
  output var   logic        second_pair_output_a,
  output var   logic        second_pair_output_b
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Balanced high time when duty correction is on
  function automatic logic [3:0] dcc_high(input logic [3:0] h, input logic [3:0] l);
    logic [5:0] n;
    logic [5:0] half;
    n    = 6'({2'h0, h} + {2'h0, l} + RATIO_BIAS);
    half = 6'((n + 6'h01) >> 1);
    return 4'(half - 6'h01);
  endfunction : dcc_high

  // Balanced low time when duty correction is on
  function automatic logic [3:0] dcc_low(input logic [3:0] h, input logic [3:0] l);
    logic [5:0] n;
    logic [5:0] half;
    n    = 6'({2'h0, h} + {2'h0, l} + RATIO_BIAS);
    half = 6'(n >> 1);
    return 4'(half - 6'h01);
  endfunction : dcc_low

  // One step of a divider
  function automatic ccdiv_div_t div_step(input ccdiv_div_t s, input ccdiv_cfg_t c,
                                          input logic sync_on);
    ccdiv_div_t n;
    n = s;
    if (c.bypass)
    begin
      // Counters parked, output toggles on every rising hclk edge
      n.cnt = CNT_ZERO;
      n.ph  = 4'h0;
      n.lvl = ~s.lvl;
    end
    else if (sync_on && c.nosync)
    begin
      n.cnt = CNT_ZERO;
      n.ph  = c.phase;
      n.lvl = c.force_hi;
    end
    else if (sync_on)
    begin
      // Held at the start level with phase reloaded until sync lifts
      n.cnt = CNT_ZERO;
      n.ph  = c.phase;
      n.lvl = c.start_hi;
    end
    else if (s.ph != 4'h0)
    begin
      n.ph = s.ph - 4'h1;
    end
    else if (s.lvl)
    begin
      if (s.cnt >= {1'b0, c.high})
      begin
        n.cnt = CNT_ZERO;
        n.lvl = 1'b0;
      end
      else
      begin
        n.cnt = s.cnt + 5'h01;
      end
    end
    else
    begin
      if (s.cnt >= {1'b0, c.low})
      begin
        n.cnt = CNT_ZERO;
        n.lvl = 1'b1;
      end
      else
      begin
        n.cnt = s.cnt + 5'h01;
      end
    end
    return n;
  endfunction : div_step

  // ************************************************************
  // Register file and bus slave
  // ************************************************************
  logic [7:0]  div0_high_low_counts;
  logic [7:0]  div0_control;
  logic [7:0]  div0_route_and_duty;
  logic [7:0]  div1_high_low_counts;
  logic [7:0]  div1_control;
  logic        wr_pend;
  logic [8:0]  wr_idx;
  logic [7:0]  next_div0_counts;
  logic [7:0]  next_div0_control;
  logic [7:0]  next_div0_route;
  logic [7:0]  next_div1_counts;
  logic [7:0]  next_div1_control;
  logic        next_wr_pend;
  logic [8:0]  next_wr_idx;
  logic [31:0] next_hrdata;
  logic        addr_ok;
  logic [8:0]  addr_idx;

  ccdiv_div_t  div0;
  ccdiv_div_t  div1;
  ccdiv_div_t  next_div0;
  ccdiv_div_t  next_div1;
  ccdiv_cfg_t  cfg0;
  ccdiv_cfg_t  cfg1;
  logic        next_first_pair;
  logic        next_second_pair;

  assign addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_idx = haddr[10:2];

  // Address phase captured, write data applied in the data phase
  always_comb
  begin
    next_div0_counts  = div0_high_low_counts;
    next_div0_control = div0_control;
    next_div0_route   = div0_route_and_duty;
    next_div1_counts  = div1_high_low_counts;
    next_div1_control = div1_control;
    next_wr_pend      = addr_ok && hwrite;
    next_wr_idx       = addr_ok ? addr_idx : wr_idx;
    next_hrdata       = hrdata;
    if (wr_pend)
    begin
      unique case (wr_idx)
        DIV0_COUNTS_IDX: next_div0_counts  = hwdata[7:0];
        DIV0_CTRL_IDX:   next_div0_control = hwdata[7:0];
        DIV0_ROUTE_IDX:  next_div0_route   = hwdata[7:0];
        DIV1_COUNTS_IDX: next_div1_counts  = hwdata[7:0];
        DIV1_CTRL_IDX:   next_div1_control = hwdata[7:0];
        default:         next_div0_counts  = div0_high_low_counts;
      endcase
    end
    // Read data is registered one edge early so it stands in the data phase
    if (addr_ok && !hwrite)
    begin
      unique case (addr_idx)
        DIV0_COUNTS_IDX: next_hrdata = {24'h000000, div0_high_low_counts};
        DIV0_CTRL_IDX:   next_hrdata = {24'h000000, div0_control};
        DIV0_ROUTE_IDX:  next_hrdata = {24'h000000, div0_route_and_duty};
        DIV1_COUNTS_IDX: next_hrdata = {24'h000000, div1_high_low_counts};
        DIV1_CTRL_IDX:   next_hrdata = {24'h000000, div1_control};
        STATUS_IDX:      next_hrdata = {28'h0000000, second_pair_output_a,
                                        first_pair_output_a, div1.lvl, div0.lvl};
        default:         next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Register bank; bus ready from the first edge after reset and always answers OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div0_high_low_counts <= COUNTS_RST;
      div0_control         <= DIV0_CTRL_RST;
      div0_route_and_duty  <= ROUTE_RST;
      div1_high_low_counts <= COUNTS_RST;
      div1_control         <= DIV1_CTRL_RST;
      wr_pend              <= 1'b0;
      wr_idx               <= 9'h000;
      hrdata               <= 32'h00000000;
      hreadyout            <= 1'b0;
      hresp                <= 1'b0;
    end
    else
    begin
      div0_high_low_counts <= next_div0_counts;
      div0_control         <= next_div0_control;
      div0_route_and_duty  <= next_div0_route;
      div1_high_low_counts <= next_div1_counts;
      div1_control         <= next_div1_control;
      wr_pend              <= next_wr_pend;
      wr_idx               <= next_wr_idx;
      hrdata               <= next_hrdata;
      hreadyout            <= 1'b1;
      hresp                <= 1'b0;
    end
  end

  // ************************************************************
  // Divider settings
  // ************************************************************

  // Duty correction only exists on divider 0; its route register holds the bit
  always_comb
  begin
    cfg0.high     = div0_high_low_counts[HIGH_MSB:HIGH_LSB];
    cfg0.low      = div0_high_low_counts[LOW_MSB:LOW_LSB];
    if (!div0_route_and_duty[DUTY_CORRECTION_DISABLE_BIT])
    begin
      cfg0.high   = dcc_high(div0_high_low_counts[HIGH_MSB:HIGH_LSB],
                             div0_high_low_counts[LOW_MSB:LOW_LSB]);
      cfg0.low    = dcc_low(div0_high_low_counts[HIGH_MSB:HIGH_LSB],
                            div0_high_low_counts[LOW_MSB:LOW_LSB]);
    end
    cfg0.bypass   = div0_control[BYPASS_BIT];
    cfg0.nosync   = div0_control[NOSYNC_BIT];
    cfg0.force_hi = div0_control[FORCE_BIT];
    cfg0.start_hi = div0_control[START_BIT];
    cfg0.phase    = div0_control[PHASE_MSB:PHASE_LSB];
    cfg1.high     = div1_high_low_counts[HIGH_MSB:HIGH_LSB];
    cfg1.low      = div1_high_low_counts[LOW_MSB:LOW_LSB];
    cfg1.bypass   = div1_control[BYPASS_BIT];
    cfg1.nosync   = div1_control[NOSYNC_BIT];
    cfg1.force_hi = div1_control[FORCE_BIT];
    cfg1.start_hi = div1_control[START_BIT];
    cfg1.phase    = div1_control[PHASE_MSB:PHASE_LSB];
  end

  // ************************************************************
  // Dividers and output routing
  // ************************************************************

  // Next divider states and routed pair levels
  always_comb
  begin
    next_div0        = div_step(div0, cfg0, !chip_sync_n);
    next_div1        = div_step(div1, cfg1, !chip_sync_n);
    next_first_pair  = div0.lvl;
    if (div0_route_and_duty[DIRECT_BIT])
    begin
      // Code 01b leaves the divider in the path
      if (src_select == SRC_OSC)
      begin
        next_first_pair = internal_oscillator;
      end
      else if (src_select == SRC_EXT)
      begin
        next_first_pair = ext_clock_level;
      end
    end
    next_second_pair = div1.lvl;
  end

  // Divider state and pin registers; outputs lag the divider by one edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div0                 <= '0;
      div1                 <= '0;
      first_pair_output_a  <= 1'b0;
      first_pair_output_b  <= 1'b0;
      second_pair_output_a <= 1'b0;
      second_pair_output_b <= 1'b0;
    end
    else
    begin
      div0                 <= next_div0;
      div1                 <= next_div1;
      first_pair_output_a  <= next_first_pair;
      first_pair_output_b  <= next_first_pair;
      second_pair_output_a <= next_second_pair;
      second_pair_output_b <= next_second_pair;
    end
  end

endmodule : ccdiv_top

// *** sim/ccdiv_properties.sv ***
// Port checker for the channel clock divider
`timescale 1ns/1ns
module ccdiv_properties
  import ccdiv_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        chip_sync_n,
  input wire logic [1:0]  src_select,
  input wire logic        internal_oscillator,
  input wire logic        ext_clock_level,
  input wire logic        first_pair_output_a,
  input wire logic        first_pair_output_b,
  input wire logic        second_pair_output_a,
  input wire logic        second_pair_output_b
);
  logic [7:0] c0, r0, n1, c1;
  logic       wp;
  logic [8:0] wi;
  logic [5:0] quiet, hi_run, lo_run;

  // Register shadows, and run counters that only trust a settled divider
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wp     <= 1'b0;
      wi     <= 9'h000;
      c0     <= DIV0_CTRL_RST;
      r0     <= ROUTE_RST;
      n1     <= COUNTS_RST;
      c1     <= DIV1_CTRL_RST;
      quiet  <= 6'h00;
      hi_run <= 6'h00;
      lo_run <= 6'h00;
    end
    else
    begin
      wp <= hsel && hready && hwrite && htrans == HTRANS_NONSEQ;
      wi <= haddr[10:2];
      if (wp && wi == DIV0_CTRL_IDX) c0 <= hwdata[7:0];
      if (wp && wi == DIV0_ROUTE_IDX) r0 <= hwdata[7:0];
      if (wp && wi == DIV1_COUNTS_IDX) n1 <= hwdata[7:0];
      if (wp && wi == DIV1_CTRL_IDX) c1 <= hwdata[7:0];
      quiet  <= (wp || !chip_sync_n) ? 6'h00 : (quiet == 6'h3F ? quiet : quiet + 6'h01);
      hi_run <= second_pair_output_a ? hi_run + 6'h01 : 6'h00;
      lo_run <= second_pair_output_a ? 6'h00 : lo_run + 6'h01;
    end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_first_pair: assert property (first_pair_output_a == first_pair_output_b)
    else $error("first pair legs differ");
  chk_second_pair: assert property (second_pair_output_a == second_pair_output_b)
    else $error("second pair legs differ");
  chk_sync_hold: assert property ((!chip_sync_n && !c1[7] && !c1[6] && $stable(c1))[*3]
    |-> second_pair_output_a == c1[4]) else $error("sync did not hold start level");
  chk_force_level: assert property ((!chip_sync_n && c1[6] && !c1[7] && $stable(c1))[*2]
    |-> second_pair_output_a == c1[5]) else $error("forced level wrong");
  chk_bypass_toggle: assert property (
    (hresetn && chip_sync_n && c0[7] && !r0[1] && $stable(c0))[*2]
    |=> first_pair_output_a != $past(first_pair_output_a)) else $error("bypass not toggling");
  chk_direct_osc: assert property (r0[1] && src_select == SRC_OSC
    |=> first_pair_output_a == $past(internal_oscillator)) else $error("oscillator route wrong");
  chk_direct_ext: assert property (r0[1] && src_select == SRC_EXT
    |=> first_pair_output_a == $past(ext_clock_level)) else $error("external route wrong");
  chk_high_time: assert property (quiet > 6'h28 && !c1[7] && $fell(second_pair_output_a)
    |-> hi_run == {2'h0, n1[3:0]} + 6'h01) else $error("high time wrong");
  chk_low_time: assert property (quiet > 6'h28 && !c1[7] && $rose(second_pair_output_a)
    |-> lo_run == {2'h0, n1[7:4]} + 6'h01) else $error("low time wrong");
  chk_bus_okay: assert property ($past(hresetn) |-> hreadyout && !hresp) // bus answer
    else $error("bus answer not ready or not okay");
endmodule : ccdiv_properties

bind ccdiv_top ccdiv_properties u_ccdiv_properties (.*);

// *** sim/ccdiv_sink.sv ***
// Far-side clock receiver that times the high and low phases of one pair
`timescale 1ns/1ns
module ccdiv_sink
(
  input  wire logic       clk_in,
  input  wire logic       hclk,
  input  wire logic       hresetn,
  output var  logic [5:0] high_len,
  output var  logic [5:0] low_len
);
  logic [5:0] run;
  logic       prev;

  // A phase is reported only when it ends, so a stuck line keeps old lengths
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      run      <= 6'h00;
      prev     <= 1'b0;
      high_len <= 6'h00;
      low_len  <= 6'h00;
    end
    else
    begin
      prev <= clk_in;
      run  <= (clk_in == prev) ? run + 6'h01 : 6'h01;
      if (clk_in != prev && prev) high_len <= run;
      if (clk_in != prev && !prev) low_len <= run;
    end
endmodule : ccdiv_sink

// *** sim/channel_clock_divider_test.sv ***
// Self-checking bench for the channel clock divider
`timescale 1ns/1ns
module channel_clock_divider_test;
  import ccdiv_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, chip_sync_n;
  logic        internal_oscillator, ext_clock_level, first_pair_output_a;
  logic        first_pair_output_b, second_pair_output_a, second_pair_output_b, p;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, src_select;
  logic [2:0]  hsize;
  logic [5:0]  h0, l0, h1, l1;
  int          fail_count = 0;
  int          check_count = 0;
  int          n0, n3;

  assign hready = hreadyout;
  ccdiv_top u_ccdiv_top (.*);
  ccdiv_sink u_ccdiv_sink0 (.clk_in(first_pair_output_a), .hclk, .hresetn,
                            .high_len(h0), .low_len(l0));
  ccdiv_sink u_ccdiv_sink1 (.clk_in(second_pair_output_a), .hclk, .hresetn,
                            .high_len(h1), .low_len(l1));

  // Clock, and two source patterns for the direct route, the external one a copy of the oscillator delayed by one edge
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // Patterns park low in reset, so this process is their only driver
  always @(posedge hclk)
  begin
    if (!hresetn)
    begin
      internal_oscillator <= 1'b0;
      ext_clock_level     <= 1'b0;
    end
    else
    begin
      internal_oscillator <= ~internal_oscillator;
      ext_clock_level     <= internal_oscillator;
    end
  end

  task summarize();
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(negedge hclk);
  endtask : cyc

  // One single transfer; request held until hready is seen high
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e, "register read");
  endtask : rdchk

  task t_regs();
    rdchk(32'h640, 32'h0);
    rdchk(32'h644, 32'h80);
    rdchk(32'h648, 32'h0);
    rdchk(32'h64C, 32'h0);
    rdchk(32'h650, 32'h0);
    wr(32'h654, 32'hFF);
    rdchk(32'h654, 32'h0);
    wr(32'h650, 32'hABCD0055);
    rdchk(32'h650, 32'h55);
    wr(32'h650, 32'h0);
  endtask : t_regs

  task t_bypass();
    cyc(1);
    p = first_pair_output_a;
    repeat (4)
    begin
      cyc(1);
      chk(first_pair_output_a, !p, "bypass toggle");
      p = first_pair_output_a;
    end
  endtask : t_bypass

  task ratio(input logic [31:0] a, input logic [7:0] v, input logic [7:0] rt,
             input logic [5:0] eh, input logic [5:0] el);
    wr(32'h648, {24'h0, rt});
    wr(a, {24'h0, v});
    cyc(100);
    chk({20'h0, a == 32'h640 ? {h0, l0} : {h1, l1}}, {20'h0, eh, el}, "phase lengths");
  endtask : ratio

  task run_sync(input logic [7:0] c, output int n);
    wr(32'h650, {24'h0, c});
    chip_sync_n <= 1'b0;
    cyc(4);
    chk(second_pair_output_a, c[4], "held level");
    @(posedge hclk);
    chip_sync_n <= 1'b1;
    n = 0;
    cyc(1);
    while (second_pair_output_a === 1'b1 && n < 40)
    begin
      n++;
      cyc(1);
    end
  endtask : run_sync

  task t_sync();
    wr(32'h64C, 32'h0);
    run_sync(8'h00, n0);
    run_sync(8'h10, n0);
    run_sync(8'h13, n3);
    chk(n3 - n0, 32'h3, "phase offset");
    wr(32'h650, 32'h50);
    chip_sync_n <= 1'b0;
    cyc(4);
    chk(second_pair_output_a, 32'h0, "forced low");
    wr(32'h650, 32'h70);
    cyc(3);
    chk(second_pair_output_a, 32'h1, "forced high");
    rdchk(32'h67C, 32'hA);
    @(posedge hclk);
    chip_sync_n <= 1'b1;
  endtask : t_sync

  task route(input logic [1:0] s, input logic osc);
    @(posedge hclk);
    src_select <= s;
    cyc(2);
    repeat (4)
    begin
      p = osc ? internal_oscillator : ext_clock_level;
      cyc(1);
      chk(first_pair_output_a, p, "direct route");
    end
  endtask : route

  initial
  begin
    {hresetn, hsel, hwrite, chip_sync_n} = 4'h1;
    {haddr, hwdata, htrans, src_select} = 68'h0;
    hsize = 3'h2;
    chip_sync_n = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_bypass();
    wr(32'h644, 32'h0);
    ratio(32'h640, 8'h31, 8'h01, 6'h02, 6'h04);
    ratio(32'h640, 8'h31, 8'h00, 6'h03, 6'h03);
    ratio(32'h640, 8'hFF, 8'h01, 6'h10, 6'h10);
    ratio(32'h64C, 8'h0F, 8'h00, 6'h10, 6'h01);
    t_sync();
    wr(32'h648, 32'h3);
    route(SRC_OSC, 1'b1);
    route(SRC_EXT, 1'b0);
    // Code 01b must hand the pair back to divider 0, which runs 16 high, 16 low
    @(posedge hclk);
    src_select <= 2'h1;
    cyc(80);
    chk({20'h0, h0, l0}, {20'h0, 6'h10, 6'h10}, "code 01b keeps divider");
    summarize();
  end

  // Watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    #160000;
    fail_count++;
    summarize();
  end
endmodule : channel_clock_divider_test
